/* File: logic/iad_access_decode.sv */
// Purpose: Access decoder for the interrupt controller registers reached by register instructions.
// Assumes: Core presents at most one request per cycle; mode bits come from logic on sys_clk.
// Notes: One answer per request, one cycle later, in request order; no pipeline drain.
//
// Functional notes
// - Writes to read-only registers fault with code zero; register unchanged.
// - Reads of write-only registers, end-of-interrupt or self-interrupt, fault.
// - Writes setting reserved bits, including bits 63:32 of every register but command, fault.
// - Reads return zero in every reserved bit position.
// - Index 831H is reserved; any access faults, nothing touched.
// - Command register is one 64-bit register at index 830H.
// - Self-interrupt register at 83FH exists only in extended mode.
// - Identifier is 32 bits, hardware loaded, read-only at 0802H.
// - Unimplemented identifier bits read back as zero.
// - Any access in 0800H..0BFFH outside extended mode faults.
// - In extended mode memory-mapped access behaves as globally disabled.
// - Register writes do not serialize; no pipeline drain is required.
// - Reads and writes take effect in program order.
// - Writes may pass earlier stores; software fences if order matters.
// - Register reads stay non-serializing in extended mode.
// - Upper 32 bits of every register except command are reserved.
// - Unassigned indices in 800H..BFFH are reserved and fault.
// - Extended mode is enable and extended bit both set.

`timescale 1ns/1ps
`default_nettype none

module iad_access_decode #(
  parameter int ID_WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,

  // Core request
  input wire iad_pkg::iad_req_t req,

  // Core answer
  output logic rsp_valid,
  output logic rsp_fault,
  output logic [63:0] rsp_rdata,

  // Mode bits of the controller base control register
  input wire logic base_enable,
  input wire logic extended_mode_bit,

  // Hardware identifier load
  input wire logic id_load,
  input wire logic [31:0] id_value,

  // Live state from the interrupt and timer logic
  input wire logic [31:0] pend_word6,
  input wire logic [31:0] pend_word7,
  input wire logic [31:0] timer_current,
  input wire logic [7:0] err_set,

  // Configuration and events toward the controller
  output var iad_pkg::iad_cfg_t cfg,
  output logic self_int_pulse,
  output logic [7:0] self_int_vector,
  output logic eoi_pulse,
  output logic command_send_pulse,
  output logic mmio_disabled
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  // Mask arithmetic below only serves 1..32 identifier bits
  if (ID_WIDTH < 1 || ID_WIDTH > 32) begin : g_bad_id_width
    $error("ID_WIDTH must lie in 1..32");
  end

  // Implemented identifier bits
  // Bits above the width are never stored, so they cannot leak into a read
  localparam logic [31:0] ID_MASK = (ID_WIDTH == 32) ? 32'hFFFF_FFFF :
                                    32'((64'h1 << ID_WIDTH) - 64'h1);

  localparam iad_pkg::iad_cfg_t CFG_RESET = '{
    corr_err_vec: iad_pkg::RST_VECTOR_TBL,
    timer_vec: iad_pkg::RST_VECTOR_TBL,
    thermal_vec: iad_pkg::RST_VECTOR_TBL,
    perf_vec: iad_pkg::RST_VECTOR_TBL,
    pin0_vec: iad_pkg::RST_VECTOR_TBL,
    pin1_vec: iad_pkg::RST_VECTOR_TBL,
    error_vec: iad_pkg::RST_VECTOR_TBL,
    init_count: iad_pkg::RST_ZERO32,
    divide: iad_pkg::RST_ZERO32,
    command: iad_pkg::RST_ZERO64
  };

  localparam iad_pkg::iad_state_t ST_RESET = '{
    cfg: CFG_RESET,
    rsp: '0,
    local_id: iad_pkg::RST_ZERO32,
    err_status: iad_pkg::RST_ZERO32,
    self_pulse: 1'b0,
    self_vector: 8'h00,
    eoi_pulse: 1'b0,
    command_pulse: 1'b0,
    mmio_disabled: 1'b0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Index decode

  // Unlisted indices, 831H among them, fall to ACC_NONE
  function automatic iad_pkg::iad_dec_t decode(input logic [31:0] index);
    iad_pkg::iad_dec_t d;
    d.acc = iad_pkg::ACC_NONE;
    d.wmask = iad_pkg::MASK_NONE;
    d.rmask = iad_pkg::MASK_NONE;
    unique case (index)
      iad_pkg::IDX_LOCAL_ID: begin
        d.acc = iad_pkg::ACC_RO;
        d.rmask = {32'h0000_0000, ID_MASK};
      end
      iad_pkg::IDX_PEND6, iad_pkg::IDX_PEND7, iad_pkg::IDX_CUR_COUNT: begin
        d.acc = iad_pkg::ACC_RO;
        d.rmask = iad_pkg::MASK_LOW32;
      end
      iad_pkg::IDX_EOI: begin
        // Only a zero write is legal
        d.acc = iad_pkg::ACC_WO;
      end
      iad_pkg::IDX_SELF_INT: begin
        d.acc = iad_pkg::ACC_WO;
        d.wmask = iad_pkg::MASK_VEC8;
      end
      iad_pkg::IDX_ERR_STATUS: begin
        // Readable, but only zero may be written
        d.acc = iad_pkg::ACC_RW;
        d.rmask = iad_pkg::MASK_ERR_STATUS;
      end
      iad_pkg::IDX_COMMAND: begin
        d.acc = iad_pkg::ACC_RW;
        d.wmask = iad_pkg::MASK_COMMAND;
        d.rmask = iad_pkg::MASK_COMMAND;
      end
      iad_pkg::IDX_CORR_ERR_VEC, iad_pkg::IDX_TIMER_VEC, iad_pkg::IDX_THERMAL_VEC,
      iad_pkg::IDX_PERF_VEC, iad_pkg::IDX_PIN0_VEC, iad_pkg::IDX_PIN1_VEC,
      iad_pkg::IDX_ERROR_VEC: begin
        d.acc = iad_pkg::ACC_RW;
        d.wmask = iad_pkg::MASK_VECTOR_TBL;
        d.rmask = iad_pkg::MASK_VECTOR_TBL;
      end
      iad_pkg::IDX_INIT_COUNT: begin
        d.acc = iad_pkg::ACC_RW;
        d.wmask = iad_pkg::MASK_LOW32;
        d.rmask = iad_pkg::MASK_LOW32;
      end
      iad_pkg::IDX_DIVIDE: begin
        d.acc = iad_pkg::ACC_RW;
        d.wmask = iad_pkg::MASK_DIVIDE;
        d.rmask = iad_pkg::MASK_DIVIDE;
      end
      default: begin
        d.acc = iad_pkg::ACC_NONE;
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  iad_pkg::iad_state_t st_q;
  iad_pkg::iad_state_t st_d;
  iad_pkg::iad_dec_t dec;
  logic ext_mode;
  logic in_window;
  logic fault;
  logic [63:0] raw;

  assign ext_mode = base_enable & extended_mode_bit;
  assign in_window = (req.index >= iad_pkg::IDX_FIRST) && (req.index <= iad_pkg::IDX_LAST);

  always_comb begin
    st_d = st_q;
    dec = decode(req.index);
    raw = 64'h0000_0000_0000_0000;
    fault = 1'b0;
    // Answer and event pulses last one cycle unless renewed
    st_d.rsp = '0;
    st_d.self_pulse = 1'b0;
    st_d.eoi_pulse = 1'b0;
    st_d.command_pulse = 1'b0;
    // Legacy window answers as if globally disabled
    st_d.mmio_disabled = ext_mode;

    // Fault classification
    // Mode gate first, so a wrong mode faults whatever the index decode returns
    if (!ext_mode) begin
      fault = 1'b1;
    end else if (!in_window || dec.acc == iad_pkg::ACC_NONE) begin
      fault = 1'b1;
    end else if (req.write) begin
      if (dec.acc == iad_pkg::ACC_RO) begin
        fault = 1'b1;
      end else if ((req.wdata & ~dec.wmask) != 64'h0000_0000_0000_0000) begin
        fault = 1'b1;
      end
    end else if (dec.acc == iad_pkg::ACC_WO) begin
      fault = 1'b1;
    end

    // Live read source before masking
    // Runs for every index; the mask and the fault gate decide what leaves
    unique case (req.index)
      iad_pkg::IDX_LOCAL_ID: raw = {32'h0000_0000, st_q.local_id};
      iad_pkg::IDX_PEND6: raw = {32'h0000_0000, pend_word6};
      iad_pkg::IDX_PEND7: raw = {32'h0000_0000, pend_word7};
      iad_pkg::IDX_CUR_COUNT: raw = {32'h0000_0000, timer_current};
      iad_pkg::IDX_ERR_STATUS: raw = {32'h0000_0000, st_q.err_status};
      iad_pkg::IDX_CORR_ERR_VEC: raw = {32'h0000_0000, st_q.cfg.corr_err_vec};
      iad_pkg::IDX_COMMAND: raw = st_q.cfg.command;
      iad_pkg::IDX_TIMER_VEC: raw = {32'h0000_0000, st_q.cfg.timer_vec};
      iad_pkg::IDX_THERMAL_VEC: raw = {32'h0000_0000, st_q.cfg.thermal_vec};
      iad_pkg::IDX_PERF_VEC: raw = {32'h0000_0000, st_q.cfg.perf_vec};
      iad_pkg::IDX_PIN0_VEC: raw = {32'h0000_0000, st_q.cfg.pin0_vec};
      iad_pkg::IDX_PIN1_VEC: raw = {32'h0000_0000, st_q.cfg.pin1_vec};
      iad_pkg::IDX_ERROR_VEC: raw = {32'h0000_0000, st_q.cfg.error_vec};
      iad_pkg::IDX_INIT_COUNT: raw = {32'h0000_0000, st_q.cfg.init_count};
      iad_pkg::IDX_DIVIDE: raw = {32'h0000_0000, st_q.cfg.divide};
      default: raw = 64'h0000_0000_0000_0000;
    endcase

    // Each request gets its answer on the next edge; no drain, no reordering
    if (req.valid) begin
      st_d.rsp.valid = 1'b1;
      st_d.rsp.fault = fault;
    end

    if (req.valid && !fault) begin
      if (!req.write) begin
        st_d.rsp.rdata = raw & dec.rmask;
      end else begin
        // Only legal writes reach here; faulting ones leave state alone
        unique case (req.index)
          iad_pkg::IDX_EOI: st_d.eoi_pulse = 1'b1;
          iad_pkg::IDX_SELF_INT: begin
            st_d.self_pulse = 1'b1;
            st_d.self_vector = req.wdata[7:0];
          end
          iad_pkg::IDX_ERR_STATUS: st_d.err_status = iad_pkg::RST_ZERO32;
          iad_pkg::IDX_CORR_ERR_VEC: st_d.cfg.corr_err_vec = req.wdata[31:0];
          iad_pkg::IDX_COMMAND: begin
            // Whole 64-bit command lands in one write
            st_d.cfg.command = req.wdata;
            st_d.command_pulse = 1'b1;
          end
          iad_pkg::IDX_TIMER_VEC: st_d.cfg.timer_vec = req.wdata[31:0];
          iad_pkg::IDX_THERMAL_VEC: st_d.cfg.thermal_vec = req.wdata[31:0];
          iad_pkg::IDX_PERF_VEC: st_d.cfg.perf_vec = req.wdata[31:0];
          iad_pkg::IDX_PIN0_VEC: st_d.cfg.pin0_vec = req.wdata[31:0];
          iad_pkg::IDX_PIN1_VEC: st_d.cfg.pin1_vec = req.wdata[31:0];
          iad_pkg::IDX_ERROR_VEC: st_d.cfg.error_vec = req.wdata[31:0];
          iad_pkg::IDX_INIT_COUNT: st_d.cfg.init_count = req.wdata[31:0];
          iad_pkg::IDX_DIVIDE: st_d.cfg.divide = req.wdata[31:0];
          default: st_d.cfg = st_q.cfg;
        endcase
      end
    end

    // New error events after the clear, so a same-cycle event survives
    st_d.err_status = st_d.err_status | {24'h00_0000, err_set};

    // Identifier only changes under hardware control
    if (id_load) begin
      st_d.local_id = id_value & ID_MASK;
    end
  end

  // One state register; reset loads constants only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from st_q
  // Pulses stand one cycle; cfg holds until the next legal write

  assign rsp_valid = st_q.rsp.valid;
  assign rsp_fault = st_q.rsp.fault;
  assign rsp_rdata = st_q.rsp.rdata;
  assign cfg = st_q.cfg;
  assign self_int_pulse = st_q.self_pulse;
  assign self_int_vector = st_q.self_vector;
  assign eoi_pulse = st_q.eoi_pulse;
  assign command_send_pulse = st_q.command_pulse;
  assign mmio_disabled = st_q.mmio_disabled;

endmodule

`default_nettype wire

/* File: logic/iad_pkg.sv */
// Purpose: Constants and types for the extended-mode register access decoder.
// Assumes: Register indices are 32-bit instruction operands from the core.
// Notes: Implemented-bit masks define the reserved bits of each register.
package iad_pkg;

  // Index window owned by the extended register interface
  localparam logic [31:0] IDX_FIRST = 32'h0000_0800;
  localparam logic [31:0] IDX_LAST = 32'h0000_0BFF;

  // Register indices
  localparam logic [31:0] IDX_LOCAL_ID = 32'h0000_0802;
  localparam logic [31:0] IDX_EOI = 32'h0000_080B;
  localparam logic [31:0] IDX_PEND6 = 32'h0000_0826;
  localparam logic [31:0] IDX_PEND7 = 32'h0000_0827;
  localparam logic [31:0] IDX_ERR_STATUS = 32'h0000_0828;
  localparam logic [31:0] IDX_CORR_ERR_VEC = 32'h0000_082F;
  localparam logic [31:0] IDX_COMMAND = 32'h0000_0830;
  localparam logic [31:0] IDX_COMMAND_HI = 32'h0000_0831;
  localparam logic [31:0] IDX_TIMER_VEC = 32'h0000_0832;
  localparam logic [31:0] IDX_THERMAL_VEC = 32'h0000_0833;
  localparam logic [31:0] IDX_PERF_VEC = 32'h0000_0834;
  localparam logic [31:0] IDX_PIN0_VEC = 32'h0000_0835;
  localparam logic [31:0] IDX_PIN1_VEC = 32'h0000_0836;
  localparam logic [31:0] IDX_ERROR_VEC = 32'h0000_0837;
  localparam logic [31:0] IDX_INIT_COUNT = 32'h0000_0838;
  localparam logic [31:0] IDX_CUR_COUNT = 32'h0000_0839;
  localparam logic [31:0] IDX_DIVIDE = 32'h0000_083E;
  localparam logic [31:0] IDX_SELF_INT = 32'h0000_083F;

  // Implemented-bit masks; every other bit is reserved
  localparam logic [63:0] MASK_NONE = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MASK_LOW32 = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] MASK_VECTOR_TBL = 64'h0000_0000_0001_FFFF;
  localparam logic [63:0] MASK_DIVIDE = 64'h0000_0000_0000_000F;
  localparam logic [63:0] MASK_VEC8 = 64'h0000_0000_0000_00FF;
  localparam logic [63:0] MASK_ERR_STATUS = 64'h0000_0000_0000_00FF;
  localparam logic [63:0] MASK_COMMAND = 64'hFFFF_FFFF_000F_FFFF;

  // Reset values
  localparam logic [31:0] RST_VECTOR_TBL = 32'h0001_0000;
  localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
  localparam logic [63:0] RST_ZERO64 = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    ACC_NONE = 2'b00,
    ACC_RO = 2'b01,
    ACC_RW = 2'b10,
    ACC_WO = 2'b11
  } iad_acc_t;

  typedef struct packed {
    iad_acc_t acc;
    logic [63:0] wmask;
    logic [63:0] rmask;
  } iad_dec_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] index;
    logic [63:0] wdata;
  } iad_req_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [63:0] rdata;
  } iad_rsp_t;

  typedef struct packed {
    logic [31:0] corr_err_vec;
    logic [31:0] timer_vec;
    logic [31:0] thermal_vec;
    logic [31:0] perf_vec;
    logic [31:0] pin0_vec;
    logic [31:0] pin1_vec;
    logic [31:0] error_vec;
    logic [31:0] init_count;
    logic [31:0] divide;
    logic [63:0] command;
  } iad_cfg_t;

  typedef struct packed {
    iad_cfg_t cfg;
    iad_rsp_t rsp;
    logic [31:0] local_id;
    logic [31:0] err_status;
    logic self_pulse;
    logic [7:0] self_vector;
    logic eoi_pulse;
    logic command_pulse;
    logic mmio_disabled;
  } iad_state_t;

endpackage

/* File: test/iad_checker.sv */
// Purpose: Concurrent checks on the register access decoder ports.
// Assumes: One clock domain; reset asynchronous, active low.
// Notes: Attached to every decoder instance by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module iad_checker #(
  parameter int ID_WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Request and answer
  input wire iad_pkg::iad_req_t req,
  input wire logic rsp_valid,
  input wire logic rsp_fault,
  input wire logic [63:0] rsp_rdata,
  // Mode and events
  input wire logic base_enable,
  input wire logic extended_mode_bit,
  input wire logic self_int_pulse,
  input wire logic command_send_pulse,
  input wire logic mmio_disabled
);
  logic ext;
  logic rd;
  logic wr;
  assign ext = base_enable & extended_mode_bit;
  assign rd = req.valid & ~req.write;
  assign wr = req.valid & req.write;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  chk_answer_next: assert property (req.valid |=> rsp_valid) else $error("no answer");
  chk_no_extra: assert property (!req.valid |=> !rsp_valid) else $error("extra answer");
  chk_mode_gate: assert property (req.valid && !ext |=> rsp_fault) else $error("mode not gated");
  chk_split_half: assert property (req.valid && req.index == iad_pkg::IDX_COMMAND_HI |=> rsp_fault)
    else $error("831 accepted");
  chk_ro_write: assert property (wr && req.index == iad_pkg::IDX_LOCAL_ID |=> rsp_fault)
    else $error("ro write accepted");
  chk_wo_read: assert property (rd && (req.index == iad_pkg::IDX_SELF_INT || req.index == iad_pkg::IDX_EOI)
    |=> rsp_fault) else $error("wo read accepted");
  chk_upper_rsvd: assert property (wr && req.index != iad_pkg::IDX_COMMAND && req.wdata[63:32] != 32'h0
    |=> rsp_fault) else $error("upper half accepted");
  chk_fault_quiet: assert property (rsp_fault |-> rsp_rdata == 64'h0 && !self_int_pulse
    && !command_send_pulse) else $error("fault with effect");
  chk_read_zero: assert property (rd && req.index != iad_pkg::IDX_COMMAND |=> rsp_rdata[63:32] == 32'h0)
    else $error("upper read nonzero");
  chk_id_width: assert property (rd && req.index == iad_pkg::IDX_LOCAL_ID
    |=> (rsp_rdata >> ID_WIDTH) == 64'h0) else $error("id bits above width");
  chk_self_send: assert property (ext && wr && req.index == iad_pkg::IDX_SELF_INT && req.wdata[63:8] == 56'h0
    |=> self_int_pulse && !rsp_fault) else $error("self write lost");
  chk_cmd_send: assert property (ext && wr && req.index == iad_pkg::IDX_COMMAND
    && (req.wdata & ~iad_pkg::MASK_COMMAND) == 64'h0 |=> command_send_pulse && !rsp_fault) else $error("cmd lost");
  chk_mmio_follow: assert property (1'b1 |=> mmio_disabled == $past(ext)) else $error("mmio flag stale");
endmodule
bind iad_access_decode iad_checker #(.ID_WIDTH(ID_WIDTH)) chk_i (.sys_clk, .arst_n, .req, .rsp_valid, .rsp_fault,
  .rsp_rdata, .base_enable, .extended_mode_bit, .self_int_pulse, .command_send_pulse, .mmio_disabled);
`default_nettype wire

/* File: test/iad_core_model.sv */
// Purpose: Core-side model issuing register read and write instructions.
// Assumes: Requests change at the falling edge, answers read a cycle on.
// Notes: Idle request lines carry inverted values so stale data never matches.
`timescale 1ns/1ps
`default_nettype none
module iad_core_model (
  // Clock
  input wire logic sys_clk,
  // Request out, answer in
  output var iad_pkg::iad_req_t req,
  input wire logic rsp_valid,
  input wire logic rsp_fault,
  input wire logic [63:0] rsp_rdata
);
  initial req = '{1'b0, 1'b0, 32'h0, 64'h0};
  ////////////////////////////////////////
  // Program order kept; callers fence before a write themselves
  task automatic access(input logic w, input logic [31:0] i, input logic [63:0] d,
      output logic ok, output logic f, output logic [63:0] q);
    ok = 1'b0;
    f = 1'b0;
    q = 64'h0;
    @(negedge sys_clk);
    req = '{1'b1, w, i, d};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge sys_clk);
      req = '{1'b0, ~w, ~i, ~d};
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        f = rsp_fault;
        q = rsp_rdata;
      end
    end
  endtask
  // Write then read with no idle cycle between
  task automatic pair(input logic [31:0] i, input logic [63:0] d, output logic [3:0] st, output logic [63:0] q);
    @(negedge sys_clk);
    req = '{1'b1, 1'b1, i, d};
    @(negedge sys_clk);
    st[3:2] = {rsp_valid, rsp_fault};
    req = '{1'b1, 1'b0, i, ~d};
    @(negedge sys_clk);
    st[1:0] = {rsp_valid, rsp_fault};
    q = rsp_rdata;
    req = '{1'b0, 1'b1, ~i, d};
  endtask
endmodule
`default_nettype wire

/* File: test/iad_access_decode_tb.sv */
// Purpose: Self-checking bench for the extended-mode register access decoder.
// Assumes: Identifier width cut to 16 so unimplemented bits are exercised.
// Notes: Inputs change at the falling edge; answers checked a cycle after issue.
`timescale 1ns/1ps
`default_nettype none
module iad_access_decode_tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic base_enable = 1'b0;
  logic extended_mode_bit = 1'b0;
  logic id_load = 1'b0;
  logic [31:0] id_value = 32'hABCD_1234;
  logic [31:0] pend_word6 = 32'h1357_9BDF;
  logic [31:0] pend_word7 = 32'h2468_ACE0;
  logic [31:0] timer_current = 32'h0000_5A5A;
  logic [7:0] err_set = 8'h00;
  iad_pkg::iad_req_t req;
  iad_pkg::iad_cfg_t cfg;
  logic rsp_valid, rsp_fault, self_int_pulse, eoi_pulse, command_send_pulse, mmio_disabled;
  logic [63:0] rsp_rdata, q, v;
  logic [7:0] self_int_vector;
  logic [3:0] st;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] rw_idx [9] = '{32'h82F, 32'h832, 32'h833, 32'h834, 32'h835, 32'h836, 32'h837, 32'h838, 32'h83E};
  logic [31:0] bad_idx [7] = '{32'h831, 32'h80E, 32'h804, 32'h900, 32'hBFF, 32'hC00, 32'h7FF};
  always #2.5 sys_clk = ~sys_clk;
  iad_access_decode #(.ID_WIDTH(16)) uut (.sys_clk, .arst_n, .req, .rsp_valid, .rsp_fault, .rsp_rdata,
    .base_enable, .extended_mode_bit, .id_load, .id_value, .pend_word6, .pend_word7, .timer_current, .err_set,
    .cfg, .self_int_pulse, .self_int_vector, .eoi_pulse, .command_send_pulse, .mmio_disabled);
  iad_core_model core (.sys_clk, .req, .rsp_valid, .rsp_fault, .rsp_rdata);
  ////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] i, input logic [63:0] d, input logic ef, input logic [63:0] eq);
    logic ok, f;
    core.access(w, i, d, ok, f, q);
    chk("answer", 64'h1, {63'h0, ok});
    if (ok !== 1'b1) begin
      give_verdict();
    end else begin
      chk("fault", {63'h0, ef}, {63'h0, f});
      chk("rdata", eq, q);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    for (int m = 0; m < 3; m++) begin
      {extended_mode_bit, base_enable} = m[1:0];
      acc(1'b0, 32'h832, 64'h0, 1'b1, 64'h0);
      acc(1'b1, 32'h832, 64'h20, 1'b1, 64'h0);
      chk("mmio", 64'h0, {63'h0, mmio_disabled});
    end
    {extended_mode_bit, base_enable} = 2'b11;
    for (int k = 0; k < 9; k++) begin
      v = (k < 7) ? 64'h1_FFFF : (k == 7) ? 64'hFFFF_FFFF : 64'hF;
      acc(1'b0, rw_idx[k], 64'h0, 1'b0, (k < 7) ? 64'h1_0000 : 64'h0);
      acc(1'b1, rw_idx[k], v, 1'b0, 64'h0);
      acc(1'b1, rw_idx[k], v + 64'h1, 1'b1, 64'h0);
      acc(1'b1, rw_idx[k], v | 64'h8000_0000_0000_0000, 1'b1, 64'h0);
      acc(1'b0, rw_idx[k], 64'h0, 1'b0, v);
    end
    chk("mmio", 64'h1, {63'h0, mmio_disabled});
    acc(1'b1, 32'h802, 64'h0, 1'b1, 64'h0);
    id_load = 1'b1; // Neither all ones nor the top 16-bit value
    @(negedge sys_clk);
    id_load = 1'b0;
    acc(1'b0, 32'h802, 64'h0, 1'b0, 64'h1234);
    acc(1'b0, 32'h826, 64'h0, 1'b0, {32'h0, pend_word6});
    acc(1'b0, 32'h827, 64'h0, 1'b0, {32'h0, pend_word7});
    acc(1'b0, 32'h839, 64'h0, 1'b0, {32'h0, timer_current});
    acc(1'b1, 32'h826, 64'h0, 1'b1, 64'h0);
    acc(1'b1, 32'h839, 64'h0, 1'b1, 64'h0);
    acc(1'b0, 32'h80B, 64'h0, 1'b1, 64'h0);
    acc(1'b0, 32'h83F, 64'h0, 1'b1, 64'h0);
    acc(1'b1, 32'h83F, 64'h41, 1'b0, 64'h0);
    chk("self", 64'h141, {55'h0, self_int_pulse, self_int_vector});
    acc(1'b1, 32'h83F, 64'h100, 1'b1, 64'h0);
    acc(1'b1, 32'h80B, 64'h1, 1'b1, 64'h0);
    acc(1'b1, 32'h80B, 64'h0, 1'b0, 64'h0);
    chk("eoi", 64'h1, {63'h0, eoi_pulse});
    for (int k = 0; k < 7; k++) begin
      acc(1'b0, bad_idx[k], 64'h0, 1'b1, 64'h0);
      acc(1'b1, bad_idx[k], 64'h0, 1'b1, 64'h0);
    end
    acc(1'b1, 32'h830, 64'hFEDC_BA98_000A_BCDE, 1'b0, 64'h0);
    chk("send", 64'h1, {63'h0, command_send_pulse});
    chk("cmd", 64'hFEDC_BA98_000A_BCDE, cfg.command);
    acc(1'b0, 32'h830, 64'h0, 1'b0, 64'hFEDC_BA98_000A_BCDE);
    acc(1'b1, 32'h830, 64'h10_0000, 1'b1, 64'h0);
    err_set = 8'h09;
    @(negedge sys_clk);
    err_set = 8'h00;
    acc(1'b0, 32'h828, 64'h0, 1'b0, 64'h9);
    acc(1'b1, 32'h828, 64'h4, 1'b1, 64'h0);
    acc(1'b1, 32'h828, 64'h0, 1'b0, 64'h0);
    acc(1'b0, 32'h828, 64'h0, 1'b0, 64'h0);
    // Event and clear taken on one edge: the event must survive
    fork
      acc(1'b1, 32'h828, 64'h0, 1'b0, 64'h0);
      begin
        @(negedge sys_clk);
        err_set = 8'h04;
        @(negedge sys_clk);
        err_set = 8'h00;
      end
    join
    acc(1'b0, 32'h828, 64'h0, 1'b0, 64'h4);
    core.pair(32'h833, 64'h1_0055, st, q);
    chk("pair", 64'hA, {60'h0, st});
    chk("pair_rd", 64'h1_0055, q);
    give_verdict();
  end
endmodule
`default_nettype wire
